// file: idec_defs.svh
// Constants of the instruction decoder: opcodes, field positions, registers
`ifndef IDEC_DEFS_SVH
`define IDEC_DEFS_SVH

// ---------------------------------------------------------------
// Program word layout
// ---------------------------------------------------------------
`define IDEC_OPC_LSB   16
`define IDEC_W2_TOP    16
`define IDEC_F_SRC     0
`define IDEC_F_WSM     4
`define IDEC_F_DST     7
`define IDEC_F_WDM     11
`define IDEC_F_WBLO    14
`define IDEC_F_TEN_LIT 4
`define IDEC_F_FADDR   0
`define IDEC_F_FWREG   13
`define IDEC_F_BIT_SEL 12
`define IDEC_F_BITIND  11
`define IDEC_F_ACC     15
`define IDEC_F_MPAIR   12
`define IDEC_F_XPF     8
`define IDEC_F_XPD     6
`define IDEC_F_YPF     2
`define IDEC_F_YPD     0
`define IDEC_F_SHREG   14
`define IDEC_F_SHAMT   8
`define IDEC_F_VAR     2

// ---------------------------------------------------------------
// Opcodes of the control class
// ---------------------------------------------------------------
`define IDEC_OPC_NOP   8'h00
`define IDEC_OPC_CBRA  8'h01
`define IDEC_OPC_CALL2 8'h02
`define IDEC_OPC_BRANCH 8'h03
`define IDEC_OPC_GOTO2 8'h04
`define IDEC_OPC_ICALL 8'h05
`define IDEC_OPC_RET   8'h06
`define IDEC_OPC_RETI  8'h07
`define IDEC_OPC_LOOP2 8'h08
`define IDEC_OPC_IGOTO 8'h09

// ---------------------------------------------------------------
// Limits, masks, reset values, register offsets
// ---------------------------------------------------------------
`define IDEC_BYTE_LIT_MAX 10'h0ff
`define IDEC_WB_DEST_BAD 2'h3
`define IDEC_MSK_MCU   9'h01f
`define IDEC_MSK_BIT   9'h010
`define IDEC_MSK_LOG   9'h014
`define IDEC_MSK_DSP   9'h1e0
`define IDEC_RST_EN    1'h1
`define IDEC_REG_CTRL  8'h00
`define IDEC_REG_STAT  8'h04
`define IDEC_REG_INFO  8'h08
`define IDEC_REG_CNT   8'h0c

`endif

// file: idec_pkg.sv
// Types shared by the instruction decoder
package idec_pkg;

  // ---------------------------------------------------------------
  // Instruction classes, taken from opcode bits 7:4
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_CTL  = 4'h0, CLS_W1 = 4'h1, CLS_W2 = 4'h2, CLS_W3 = 4'h3,
    CLS_W4   = 4'h4, CLS_W5 = 4'h5, CLS_W6 = 4'h6, CLS_W7 = 4'h7,
    CLS_FILE = 4'h8, CLS_LIT = 4'h9, CLS_BIT = 4'ha, CLS_TBL = 4'hb,
    CLS_MAC  = 4'hc, CLS_DSP = 4'hd, CLS_SKIP = 4'he, CLS_MOV = 4'hf
  } idec_cls_t;

  typedef enum logic [1:0] {
    VAR_WORD = 2'h0, VAR_BYTE = 2'h1, VAR_DBL = 2'h2, VAR_SHAD = 2'h3
  } idec_var_t;

  typedef enum logic [1:0] {
    S_RUN = 2'b00, S_WORD2 = 2'b01, S_STALL = 2'b10, S_SKIP2 = 2'b11
  } idec_state_t;

  typedef struct packed {
    logic acc_two_saturate;
    logic acc_one_saturate;
    logic acc_two_overflow;
    logic acc_one_overflow;
    logic zero;
    logic overflow_flag;
    logic negative;
    logic digit_carry_flag;
    logic carry;
  } idec_flags_t;

  typedef struct packed {
    logic [7:0]  opcode;
    idec_cls_t   cls;
    idec_var_t   variant;
    logic        two_word;
    logic [1:0]  cycles;
    logic [3:0]  base_src_reg;
    logic [3:0]  second_src_reg;
    logic [2:0]  src_mode;
    logic [3:0]  dest_reg;
    logic [2:0]  dest_mode;
    logic [12:0] file_addr;
    logic        dest_is_default_work_reg;
    logic [3:0]  bit_select_field;
    logic        bit_from_reg;
    logic [9:0]  ten_bit_literal;
    logic [15:0] signed_ten_bit_literal;
    logic [15:0] signed_sixteen_bit_literal;
    logic [22:0] program_address_literal;
    logic        acc_sel;
    logic [2:0]  mul_pair;
    logic [3:0]  x_prefetch;
    logic [1:0]  x_prefetch_dest;
    logic [3:0]  y_prefetch;
    logic [1:0]  y_prefetch_dest;
    logic [1:0]  acc_writeback_dest;
    logic        shift_from_reg;
    logic [3:0]  shift_amount_reg;
    logic [5:0]  shift_literal;
    logic [8:0]  flag_mask;
    logic        lit_err;
    logic        addr_err;
    logic        word2_err;
    logic        wb_dest_err;
  } idec_dec_t;

endpackage

// file: idec_decoder.sv
// Instruction decoder with issue sequencing and an APB status port
`timescale 1ns/1ns
`include "idec_defs.svh"

// Contract
// [RULE_01] One 24-bit word; three two-word types
// [RULE_02] 8-bit opcode, remaining bits are operands
// [RULE_03] Second word upper eight bits must be zero
// [RULE_04] Lone second word executes as no-operation
// [RULE_05] One cycle; taken condition adds one
// [RULE_06] Branches, tables, returns take two or three
// [RULE_07] Skip costs two or three cycles
// [RULE_08] Double moves and two-word take two
// [RULE_09] Decode base, second source and destination
// [RULE_10] File address 13 bits, destination file/W0
// [RULE_11] Bit select from literal or register
// [RULE_12] Literal ops: base register, literal, destination
// [RULE_13] MAC: accumulator, pair, prefetches, write-back
// [RULE_14] Write-back only W13 or post-increment
// [RULE_15] DSP: accumulator, operand, shift amount
// [RULE_16] Ten-bit literal below 256 in byte mode
// [RULE_17] Program address literal bit zero clear
// [RULE_18] Signed literals in two's complement
// [RULE_19] Update core and accumulator status bits
// [RULE_20] Byte, double, shadow variants; word default
// [RULE_21] Hold until both words fetched
module idec_decoder (
  input  wire logic                  clk_sys,
  input  wire logic                  sys_rst,
  input  wire logic                  fetch_valid,
  input  wire logic [23:0]           fetch_word,
  output logic                       fetch_ready,
  input  wire logic                  cond_taken,
  input  wire logic                  skip_taken,
  input  wire logic                  flag_upd,
  input  wire idec_pkg::idec_flags_t flag_val,
  output logic                       dec_valid,
  output logic                       dec_nop,
  output idec_pkg::idec_dec_t        dec,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr
);

  // ---------------------------------------------------------------
  // Decode functions
  // ---------------------------------------------------------------
  function automatic logic is_two(input logic [7:0] op);
    is_two = (op == `IDEC_OPC_CALL2) || (op == `IDEC_OPC_GOTO2) ||
             (op == `IDEC_OPC_LOOP2); // RULE_01
  endfunction

  function automatic logic [1:0] cyc_fn(input logic [7:0] op);
    idec_pkg::idec_cls_t c;
    c = idec_pkg::idec_cls_t'(op[7:4]);
    if (is_two(op)) begin
      cyc_fn = 2'h2; // RULE_08
    end else begin
      case (op)
        `IDEC_OPC_BRANCH, `IDEC_OPC_CBRA,
        `IDEC_OPC_ICALL, `IDEC_OPC_IGOTO: cyc_fn = 2'h2; // RULE_06
        `IDEC_OPC_RET, `IDEC_OPC_RETI:   cyc_fn = 2'h3; // RULE_06
        default: begin
          if (c == idec_pkg::CLS_TBL) begin
            cyc_fn = 2'h2; // RULE_06
          end else if (c != idec_pkg::CLS_CTL &&
                       op[`IDEC_F_VAR +: 2] == idec_pkg::VAR_DBL) begin
            cyc_fn = 2'h2; // RULE_08
          end else begin
            cyc_fn = 2'h1; // RULE_05
          end
        end
      endcase
    end
  endfunction

  function automatic logic [8:0] mask_fn(input idec_pkg::idec_cls_t c);
    case (c)
      idec_pkg::CLS_W1, idec_pkg::CLS_W2, idec_pkg::CLS_W3,
      idec_pkg::CLS_W4, idec_pkg::CLS_FILE,
      idec_pkg::CLS_LIT:  mask_fn = `IDEC_MSK_MCU; // RULE_19
      idec_pkg::CLS_W5, idec_pkg::CLS_W6,
      idec_pkg::CLS_W7:   mask_fn = `IDEC_MSK_LOG; // RULE_19
      idec_pkg::CLS_BIT,
      idec_pkg::CLS_SKIP: mask_fn = `IDEC_MSK_BIT; // RULE_19
      idec_pkg::CLS_MAC,
      idec_pkg::CLS_DSP:  mask_fn = `IDEC_MSK_DSP; // RULE_19
      default:            mask_fn = 9'h000;
    endcase
  endfunction

  function automatic idec_pkg::idec_dec_t dec_fn(
    input logic [23:0] w1,
    input logic [23:0] w2,
    input logic        tw
  );
    idec_pkg::idec_dec_t d;
    d = '0;
    d.opcode   = w1[`IDEC_OPC_LSB +: 8]; // RULE_02
    d.cls      = idec_pkg::idec_cls_t'(d.opcode[7:4]);
    d.variant  = idec_pkg::idec_var_t'(d.opcode[`IDEC_F_VAR +: 2]); // RULE_20
    d.two_word = tw;
    d.cycles   = cyc_fn(d.opcode);
    d.base_src_reg   = {d.opcode[1:0], w1[`IDEC_F_WBLO +: 2]}; // RULE_09
    d.second_src_reg = w1[`IDEC_F_SRC +: 4]; // RULE_09
    d.src_mode       = w1[`IDEC_F_WSM +: 3];
    d.dest_reg       = w1[`IDEC_F_DST +: 4]; // RULE_09
    d.dest_mode      = w1[`IDEC_F_WDM +: 3];
    d.file_addr      = w1[`IDEC_F_FADDR +: 13]; // RULE_10
    d.dest_is_default_work_reg = w1[`IDEC_F_FWREG]; // RULE_10
    d.bit_select_field = w1[`IDEC_F_BIT_SEL +: 4]; // RULE_11
    d.bit_from_reg     = w1[`IDEC_F_BITIND]; // RULE_11
    d.ten_bit_literal  = w1[`IDEC_F_TEN_LIT +: 10]; // RULE_12
    d.signed_ten_bit_literal =
      {{6{w1[`IDEC_F_TEN_LIT + 9]}}, w1[`IDEC_F_TEN_LIT +: 10]}; // RULE_18
    d.signed_sixteen_bit_literal = w1[15:0]; // RULE_18
    d.program_address_literal = {w2[6:0], w1[15:0]};
    d.acc_sel         = w1[`IDEC_F_ACC]; // RULE_13
    d.mul_pair        = w1[`IDEC_F_MPAIR +: 3];
    d.x_prefetch      = w1[`IDEC_F_XPF +: 4]; // RULE_13
    d.x_prefetch_dest = w1[`IDEC_F_XPD +: 2];
    d.y_prefetch      = w1[`IDEC_F_YPF +: 4];
    d.y_prefetch_dest = w1[`IDEC_F_YPD +: 2];
    d.acc_writeback_dest = d.opcode[1:0]; // RULE_13
    d.shift_from_reg   = w1[`IDEC_F_SHREG]; // RULE_15
    d.shift_amount_reg = w1[`IDEC_F_SHAMT +: 4]; // RULE_15
    d.shift_literal    = w1[`IDEC_F_SHAMT +: 6];
    d.flag_mask        = mask_fn(d.cls);
    d.lit_err  = d.cls == idec_pkg::CLS_LIT &&
                 d.variant == idec_pkg::VAR_BYTE &&
                 d.ten_bit_literal > `IDEC_BYTE_LIT_MAX; // RULE_16
    d.addr_err = tw && w1[0]; // RULE_17
    d.word2_err = tw && (w2[`IDEC_W2_TOP +: 8] != 8'h00); // RULE_03
    d.wb_dest_err = d.cls == idec_pkg::CLS_MAC &&
                    d.acc_writeback_dest == `IDEC_WB_DEST_BAD; // RULE_14
    dec_fn = d;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  idec_pkg::idec_state_t state_q, state_d;
  idec_pkg::idec_dec_t   dec_q, dec_d;
  logic [23:0]           w1_q, w1_d;
  logic [1:0]            cnt_q, cnt_d;
  logic                  skp_q, skp_d;
  logic                  ready_q, ready_d;
  logic                  valid_q, nop_q;
  logic                  issue, nop;
  logic                  en_q;
  logic [3:0]            err_q;
  logic                  err_clr;
  idec_pkg::idec_flags_t stat_q;
  logic [31:0]           cnt32_q;
  logic [31:0]           rdata_q;
  logic                  pready_q, pslverr_q;
  logic                  accept, squash, tw_in;
  logic                  apb_wr;

  assign accept = fetch_valid & ready_q;
  assign squash = valid_q & (cond_taken | skip_taken);
  assign tw_in  = is_two(fetch_word[`IDEC_OPC_LSB +: 8]);

  // ---------------------------------------------------------------
  // Issue sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    dec_d   = dec_q;
    w1_d    = w1_q;
    cnt_d   = cnt_q;
    skp_d   = skp_q;
    issue   = 1'b0;
    nop     = 1'b0;
    case (state_q)
      idec_pkg::S_RUN: begin
        if (accept) begin
          if (skp_q | squash) begin
            nop   = 1'b1; // RULE_05
            skp_d = 1'b0;
            if (tw_in & (skp_q | skip_taken)) begin
              state_d = idec_pkg::S_SKIP2; // RULE_07
            end
          end else if (tw_in) begin
            w1_d    = fetch_word;
            state_d = idec_pkg::S_WORD2; // RULE_21
          end else if (fetch_word[`IDEC_OPC_LSB +: 8] ==
                       `IDEC_OPC_NOP) begin
            nop = 1'b1; // RULE_04
          end else begin
            issue = 1'b1;
            dec_d = dec_fn(fetch_word, 24'h000000, 1'b0);
            if (dec_d.cycles > 2'h1) begin
              cnt_d   = dec_d.cycles - 2'h1; // RULE_06
              state_d = idec_pkg::S_STALL;
            end
          end
        end else if (squash) begin
          if (skip_taken) begin
            skp_d = 1'b1; // RULE_07
          end else begin
            cnt_d   = 2'h1; // RULE_05
            state_d = idec_pkg::S_STALL;
          end
        end
      end
      idec_pkg::S_WORD2: begin
        if (accept) begin
          issue   = 1'b1;
          dec_d   = dec_fn(w1_q, fetch_word, 1'b1); // RULE_21
          cnt_d   = 2'h1; // RULE_08
          state_d = idec_pkg::S_STALL;
        end
      end
      idec_pkg::S_STALL: begin
        nop   = 1'b1;
        cnt_d = cnt_q - 2'h1;
        if (cnt_q <= 2'h1) begin
          state_d = idec_pkg::S_RUN;
        end
      end
      idec_pkg::S_SKIP2: begin
        if (accept) begin
          nop     = 1'b1; // RULE_07
          state_d = idec_pkg::S_RUN;
        end
      end
      default: begin
        state_d = idec_pkg::S_RUN;
      end
    endcase
    ready_d = en_q & (state_d != idec_pkg::S_STALL);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= idec_pkg::S_RUN;
      cnt_q   <= 2'h0;
      skp_q   <= 1'b0;
      w1_q    <= 24'h000000;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      skp_q   <= skp_d;
      w1_q    <= w1_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      valid_q <= 1'b0;
      nop_q   <= 1'b0;
      dec_q   <= '0;
    end else begin
      valid_q <= issue;
      nop_q   <= nop;
      dec_q   <= dec_d;
    end
  end

  // ---------------------------------------------------------------
  // Status bits and counters
  // ---------------------------------------------------------------
  // Flags follow the mask of the instruction now on the datapath
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_q <= '0;
    end else if (flag_upd & valid_q) begin
      stat_q <= (stat_q & ~dec_q.flag_mask) |
                (flag_val & dec_q.flag_mask); // RULE_19
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      err_q <= 4'h0;
    end else begin
      err_q <= (err_clr ? 4'h0 : err_q) |
               ({4{issue}} & {dec_d.wb_dest_err, dec_d.word2_err,
                              dec_d.addr_err, dec_d.lit_err});
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt32_q <= 32'h00000000;
    end else if (err_clr) begin
      cnt32_q <= 32'h00000000;
    end else if (valid_q | nop_q) begin
      cnt32_q <= cnt32_q + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // No wait state: prdata and pready come straight from flops loaded in the setup cycle
  assign apb_wr  = psel & penable & pready_q & pwrite;
  assign err_clr = apb_wr & (paddr[7:0] == `IDEC_REG_CTRL) &
                   (paddr[31:8] == 24'h000000) & pwdata[1];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rdata_q   <= 32'h00000000;
    end else if (psel & ~penable) begin
      pready_q  <= 1'b1;
      pslverr_q <= 1'b0;
      rdata_q   <= 32'h00000000;
      if (paddr[31:8] != 24'h000000) begin
        pslverr_q <= 1'b1;
      end else begin
        case (paddr[7:0])
          `IDEC_REG_CTRL: rdata_q <= {31'h00000000, en_q};
          `IDEC_REG_STAT: rdata_q <= {23'h000000, stat_q};
          `IDEC_REG_INFO: rdata_q <= {20'h00000, err_q, dec_q.opcode};
          `IDEC_REG_CNT:  rdata_q <= cnt32_q;
          default:        pslverr_q <= 1'b1;
        endcase
      end
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en_q <= `IDEC_RST_EN;
    end else if (apb_wr & (paddr == {24'h000000, `IDEC_REG_CTRL})) begin
      en_q <= pwdata[0];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign fetch_ready = ready_q;
  assign dec_valid   = valid_q;
  assign dec_nop     = nop_q;
  assign dec         = dec_q;
  assign prdata      = rdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;

endmodule // idec_decoder

// file: idec_props.sv
// Port-level checks for the instruction decoder
`timescale 1ns/1ns
module idec_props (
  input wire logic                clk_sys,
  input wire logic                sys_rst,
  input wire logic                fetch_valid,
  input wire logic [23:0]         fetch_word,
  input wire logic                fetch_ready,
  input wire logic                cond_taken,
  input wire logic                dec_valid,
  input wire logic                dec_nop,
  input wire idec_pkg::idec_dec_t dec,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [31:0]         paddr,
  input wire logic                pready,
  input wire logic                pslverr
);
  logic take;
  assign take = fetch_valid && fetch_ready;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ------------
  // Issue timing
  // ------------
  sequence s_two_nops;
    dec_nop && !dec_valid ##1 dec_nop && !dec_valid;
  endsequence
  a_nop_after_two: assert property (dec_valid &&
    (dec.cycles == 2'd2 || cond_taken) |=> dec_nop && !dec_valid)
    else $error("filler cycle missing");
  a_nops_after_three: assert property (
    dec_valid && dec.cycles == 2'd3 |=> s_two_nops)
    else $error("two filler cycles missing");
  a_stall_fetch: assert property (
    dec_valid && dec.cycles > 2'd1 |-> !fetch_ready)
    else $error("word taken during stall");
  // Both words must have been taken on the two edges before issue
  a_pair_fetched: assert property (
    dec_valid && dec.two_word |-> $past(take) && $past(take, 2))
    else $error("two-word issued early");
  a_word2_zero: assert property (
    dec_valid && dec.two_word |->
    dec.word2_err == ($past(fetch_word[23:16]) != 8'h00))
    else $error("second word check wrong");
  a_opcode_split: assert property (
    dec_valid && !dec.two_word |-> dec.opcode == $past(fetch_word[23:16])
    && dec.cls == $past(fetch_word[23:20]))
    else $error("opcode field wrong");
  a_lit_range: assert property (
    dec_valid && dec.cls == idec_pkg::CLS_LIT |-> dec.lit_err ==
    (dec.variant == idec_pkg::VAR_BYTE && dec.ten_bit_literal > 10'h0ff))
    else $error("literal range flag wrong");
  a_addr_even: assert property (
    dec_valid && dec.two_word |->
    dec.addr_err == dec.program_address_literal[0])
    else $error("address parity flag wrong");
  a_wb_dest_limit: assert property (
    dec_valid && dec.cls == idec_pkg::CLS_MAC |->
    dec.wb_dest_err == (dec.acc_writeback_dest == 2'h3))
    else $error("write-back flag wrong");
  a_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer timing wrong");
  a_apb_refuse: assert property (pready |->
    pslverr == !(paddr inside {32'h0, 32'h4, 32'h8, 32'hc}))
    else $error("bus refusal wrong");
endmodule // idec_props

// file: idec_fetch_model.sv
// Program fetch and execute-side model facing the decoder
`timescale 1ns/1ns
module idec_fetch_model (
  input  wire logic   clk_sys,
  input  wire logic   sys_rst,
  input  wire logic   fetch_ready,
  input  wire logic   dec_valid,
  input  wire logic   slow,
  input  wire logic   cond_arm,
  input  wire logic   skip_arm,
  input  wire logic   flag_arm,
  output logic        fetch_valid,
  output logic [23:0] fetch_word,
  output logic        cond_taken,
  output logic        skip_taken,
  output logic        flag_upd
);
  logic [23:0] mem_q[$];
  logic        taken;
  initial begin
    fetch_valid = 1'b0;
    fetch_word = 24'h0;
  end
  task automatic push(input logic [23:0] w);
    mem_q.push_back(w);
  endtask
  // Execute side answers in the issue cycle itself
  assign cond_taken = dec_valid && cond_arm;
  assign skip_taken = dec_valid && skip_arm;
  assign flag_upd   = dec_valid && flag_arm;
  // Idle bus toggles so a stale word never looks like a real one
  always @(posedge clk_sys) begin
    taken = fetch_valid && fetch_ready;
    if (taken) void'(mem_q.pop_front());
    if (!sys_rst && mem_q.size() != 0 && !(taken && slow)) begin
      fetch_valid <= 1'b1;
      fetch_word <= mem_q[0];
    end else begin
      fetch_valid <= 1'b0;
      fetch_word <= ~fetch_word;
    end
  end
endmodule // idec_fetch_model

// file: testbench.sv
// Top-level bench for the instruction decoder
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, slow = 1'b0, cond_arm = 1'b0, skip_arm = 1'b0;
  logic flag_arm = 1'b0, fetch_valid, fetch_ready, cond_taken, skip_taken;
  logic flag_upd, dec_valid, dec_nop, pready, pslverr, err;
  logic [23:0]           fetch_word;
  logic [31:0]           paddr = '0, pwdata = '0, prdata, rd;
  idec_pkg::idec_flags_t flag_val = '0;
  idec_pkg::idec_dec_t   dec, last;
  logic [7:0]            op;
  logic [15:0]           lo;
  logic [9:0]  lits[3] = '{10'h100, 10'h0ff, 10'h3ff};
  logic [7:0]  ctl[7] = '{8'h01, 8'h03, 8'h05, 8'h09, 8'h06, 8'h07, 8'hb0};
  logic [23:0] tw[6] = '{24'h021234, 24'h000056, 24'h041235, 24'h000001,
                         24'h082222, 24'h010000};
  logic [7:0]  fop[4] = '{8'h10, 8'ha0, 8'hc0, 8'h50};
  logic [8:0]  fv[4] = '{9'h1ff, 9'h000, 9'h1ff, 9'h000};
  logic [8:0]  fex[4] = '{9'h01f, 9'h00f, 9'h1ef, 9'h1eb};
  int nv = 0, nn = 0, v0 = 0, n0 = 0, n_mismatch = 0, total_checks = 0;
  int cyc = 0;
  idec_decoder i_idec_decoder (.clk_sys, .sys_rst, .fetch_valid,
    .fetch_word, .fetch_ready, .cond_taken, .skip_taken, .flag_upd,
    .flag_val, .dec_valid, .dec_nop, .dec, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);
  idec_fetch_model i_idec_fetch_model (.clk_sys, .sys_rst, .fetch_ready,
    .dec_valid, .slow, .cond_arm, .skip_arm, .flag_arm, .fetch_valid,
    .fetch_word, .cond_taken, .skip_taken, .flag_upd);
  always #5 clk_sys = ~clk_sys;
  // ---------------
  // Tasks and monitor
  // ---------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // No back-to-back transfers: an idle cycle keeps psel single-driven
  task automatic apb(input logic wr, input logic [31:0] a, d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic feed(input logic [23:0] ws[$]);
    foreach (ws[i]) i_idec_fetch_model.push(ws[i]);
  endtask
  // Longest instruction is three slots, so four idle edges close it
  task automatic settle(input int ev, en, input string nm);
    while (fetch_valid === 1'b1 ||
           i_idec_fetch_model.mem_q.size() != 0) begin
      @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
    chk({nm, " issues"}, nv - v0, ev);
    chk({nm, " fillers"}, nn - n0, en);
    v0 = nv;
    n0 = nn;
  endtask
  task automatic one(input logic [23:0] w, input int en);
    feed('{w});
    settle(1, en, "issue");
  endtask
  always @(posedge clk_sys) begin
    if (dec_valid === 1'b1) begin
      nv++;
      last = dec;
    end
    if (dec_nop === 1'b1) nn++;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ---------------
  // Main sequence
  // ---------------
  initial begin
    repeat (8) @(posedge clk_sys);
    chk("ready in reset", fetch_ready, 0);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 32'(i * 4), 0);
      chk("reg reset", rd, i == 0);
      chk("reg refuse", err, i == 4);
    end
    lo = 16'hb5a9;
    for (int v = 0; v < 4; v++) begin
      op = {4'h1, 2'(v), 2'h2};
      one({op, lo}, v == 2);
      chk("class", last.cls, op[7:4]);
      chk("variant", last.variant, v);
      chk("cycles", last.cycles, (v == 2) + 1);
      chk("base", last.base_src_reg, {op[1:0], lo[15:14]});
      chk("src", {last.src_mode, last.second_src_reg}, lo[6:0]);
      chk("dest", {last.dest_mode, last.dest_reg}, lo[13:7]);
    end
    one(24'h803fff, 0);
    chk("file", {last.dest_is_default_work_reg, last.file_addr},
        14'h3fff);
    one(24'ha05800, 0);
    chk("bit", {last.bit_select_field, last.bit_from_reg}, 5'h0b);
    lo = 16'h4a3c;
    one({8'hd0, lo}, 0);
    chk("dsp", {last.acc_sel, last.shift_from_reg}, lo[15:14]);
    chk("shift", {last.shift_amount_reg, last.shift_literal},
        {lo[11:8], lo[13:8]});
    for (int i = 0; i < 3; i++) begin
      op = (i < 2) ? 8'h94 : 8'h90;
      lo = {2'h1, lits[i], 4'h3};
      one({op, lo}, 0);
      chk("lit err", last.lit_err, lits[i] > 10'h0ff && i < 2);
      chk("signed_ten_bit_literal", last.signed_ten_bit_literal,
          {{6{lits[i][9]}}, lits[i]});
      chk("signed_sixteen_bit_literal", last.signed_sixteen_bit_literal, lo);
      chk("lit base", last.base_src_reg, {op[1:0], lo[15:14]});
    end
    lo = 16'hd6e7;
    for (int a = 0; a < 4; a++) begin
      one({6'h30, 2'(a), lo}, 0);
      chk("mac", {last.acc_sel, last.mul_pair, last.x_prefetch,
          last.x_prefetch_dest, last.y_prefetch, last.y_prefetch_dest}, lo);
      chk("wb dest err", last.wb_dest_err, a == 3);
    end
    for (int i = 0; i < 7; i++) begin
      one({ctl[i], 16'h0},
          (ctl[i] == 8'h06 || ctl[i] == 8'h07) + 1);
    end
    for (int i = 0; i < 3; i++) begin
      feed('{tw[2*i], tw[2*i+1]});
      settle(1, 1, "pair");
      chk("two word", last.two_word, 1);
      chk("prog addr", last.program_address_literal,
          {tw[2*i+1][6:0], tw[2*i][15:0]});
      chk("addr err", last.addr_err, tw[2*i][0]);
      chk("w2 err", last.word2_err, tw[2*i+1][23:16] != 0);
    end
    feed('{24'h000456});
    settle(0, 1, "orphan");
    cond_arm <= 1'b1;
    feed('{24'h10b5a9, 24'h11b5a9});
    settle(1, 1, "cond");
    cond_arm <= 1'b0;
    skip_arm <= 1'b1;
    feed('{24'he00000, 24'h10b5a9});
    settle(1, 1, "skip one");
    slow <= 1'b1;
    feed('{24'he00000, 24'h021234, 24'h000056});
    settle(1, 2, "skip two");
    skip_arm <= 1'b0;
    slow <= 1'b0;
    flag_arm <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      flag_val <= fv[i];
      one({fop[i], 16'h0}, 0);
      apb(1'b0, 32'h4, 0);
      chk("status", rd, fex[i]);
    end
    apb(1'b0, 32'h8, 0);
    chk("errors", rd[11:0], 12'hf50);
    apb(1'b1, 32'h0, 32'h2);
    apb(1'b0, 32'h8, 0);
    chk("cleared", rd[11:8], 0);
    feed('{24'h10b5a9});
    repeat (5) @(posedge clk_sys);
    chk("held", nv - v0, 0);
    apb(1'b1, 32'h0, 32'h1);
    settle(1, 0, "resume");
    apb(1'b0, 32'hc, 0);
    chk("count", rd, 1);
    end_of_test();
  end
endmodule // testbench

bind idec_decoder idec_props i_idec_props (.clk_sys, .sys_rst, .fetch_valid,
  .fetch_word, .fetch_ready, .cond_taken, .dec_valid, .dec_nop, .dec, .psel,
  .penable, .paddr, .pready, .pslverr);
